// File: hdl/svps_sequencer.sv
// Purpose: Device side of the low-voltage serial program/verify link
// Assumes: Link pins are asynchronous and sampled by clk
// Notes:   Array writes leave on nvmWrite, one byte per strobe
// Functional notes
// - Entry only with low-voltage enable bit set
// - Select pin stops being general purpose I/O
// - Entry puts unused I/O in high impedance
// - Second key at lower address erases whole device
// - Start command programs buffer region holding pointer
// - Buffers map on naturally aligned regions
// - Programming lasts while fourth clock stays high
// - Clock low ends programming; programmer holds discharge
// - Write buffer per variant, erase buffer 64
// - EEPROM byte writes, erase before write
// - EEPROM write on 4th fall; hardware clears start
// - Eight ID bytes at fixed addresses, readable; code programs ID space as a full 64-byte buffer and has no read path
// - Increment write stores two bytes, pointer plus two
// - Config writes one byte: low even, high odd
// - Command 0000 runs payload as core instruction
// - Command bits shift in least significant first
module svps_sequencer (
    input  wire logic                      clk,                   // 50 MHz
    input  wire logic                      reset,                 // Sync, high
    input  wire logic                      lowVoltageEntryEnable, // Config bit
    input  wire logic                      progSerialClockPin,    // Link clock
    input  wire logic                      progSerialDataPin,     // Link data
    input  wire logic                      lowVoltageProgSelectPin, // Select
    input  wire logic                      masterClearPin,        // Mode pin
    output logic                           progModeActive,        // In mode
    output logic                           unusedIoHighZ,         // I/O off
    output logic                           sharedPinGpioEnable,   // GPIO use
    output logic                           programPulse,          // Pulse on
    output logic                           eraseBusy,             // Erasing
    output logic                           eeWriteBusy,           // EE write
    output logic [7:0]                     writeControl,          // Control
    output svps_pkg::svps_nvm_write_s      nvmWrite               // Byte out
);
    // Pin order: 0 clock, 1 data, 2 select, 3 master clear
    logic [3:0]                  sync1_q, sync2_q;
    logic                        pgcPrev_q, mclrPrev_q;
    logic                        pgcRise, pgcFall, mclrRise;
    svps_pkg::svps_state_e       state_q, state_d;
    logic                        inMode_q, inMode_d, gpioEn_q, gpioEn_d;
    logic [4:0]                  bitCnt_q, bitCnt_d;
    logic [19:0]                 shift_q, shift_d, frame;
    logic [7:0]                  wreg_q, wreg_d, nvctrl_q, nvctrl_d;
    logic [21:0]                 tbl_q, tbl_d, progBase_q, progBase_d;
    logic [15:0]                 eeAddr_q, eeAddr_d;
    logic [7:0]                  eeprom_data_latch_q, eeprom_data_latch_d, cfgByte_q, cfgByte_d;
    logic                        eraseArmed_q, eraseArmed_d;
    logic                        progArmed_q, progArmed_d;
    logic                        cfgProg_q, cfgProg_d;
    logic [6:0]                  walkIdx_q, walkIdx_d, walkLen;
    logic [2:0]                  eeFall_q, eeFall_d;
    logic [8:0]                  eraseTmr_q, eraseTmr_d, eeTmr_q, eeTmr_d;
    logic                        pulse_q, pulse_d;
    svps_pkg::svps_nvm_write_s   nvm_q, nvm_d;
    logic [15:0]                 wordBuf [svps_pkg::WRITE_BUF_BYTES / 2];
    logic                        bufWe;
    logic [15:0]                 op;
    logic                        fileWe, wrNow, eraseStart, inc2Exec;
    logic [7:0]                  fileVal, fileCur;

    // Two-flop synchronisers, then edge history on the second stage
    always_ff @(posedge clk) begin
        if (reset) begin
            sync1_q    <= 4'h0;
            sync2_q    <= 4'h0;
            pgcPrev_q  <= 1'b0;
            mclrPrev_q <= 1'b0;
        end else begin
            sync1_q    <= {masterClearPin, lowVoltageProgSelectPin,
                           progSerialDataPin, progSerialClockPin};
            sync2_q    <= sync1_q;
            pgcPrev_q  <= sync2_q[0];
            mclrPrev_q <= sync2_q[3];
        end
    end

    assign pgcRise  = sync2_q[0] & ~pgcPrev_q;
    assign pgcFall  = ~sync2_q[0] & pgcPrev_q;
    assign mclrRise = sync2_q[3] & ~mclrPrev_q;
    assign frame    = {sync2_q[1], shift_q[19:1]};
    assign op       = frame[19:4];
    assign walkLen  = cfgProg_q ? svps_pkg::WALK_ONE
                                : svps_pkg::WALK_FULL;

    // Current value of the file addressed by a bit set or clear
    always_comb begin
        case (op[7:0])
            svps_pkg::FILE_TBL_U:     fileCur = {2'h0, tbl_q[21:16]};
            svps_pkg::FILE_TBL_H:     fileCur = tbl_q[15:8];
            svps_pkg::FILE_TBL_L:     fileCur = tbl_q[7:0];
            // Start bit masked: setting another bit never re-arms a write
            svps_pkg::FILE_NVCTRL:    fileCur = nvctrl_q &
                ~(8'h01 << svps_pkg::CTRL_WR);
            svps_pkg::FILE_EE_DATA:   fileCur = eeprom_data_latch_q;
            svps_pkg::FILE_EE_ADDR_L: fileCur = eeAddr_q[7:0];
            svps_pkg::FILE_EE_ADDR_H: fileCur = eeAddr_q[15:8];
            default:                  fileCur = 8'h00;
        endcase
    end

    // Sequencer next state
    always_comb begin
        state_d = state_q;        inMode_d = inMode_q;   gpioEn_d = gpioEn_q;
        bitCnt_d = bitCnt_q;      shift_d = shift_q;     wreg_d = wreg_q;
        nvctrl_d = nvctrl_q;      tbl_d = tbl_q;         progBase_d = progBase_q;
        eeAddr_d = eeAddr_q;      eeprom_data_latch_d = eeprom_data_latch_q;   cfgByte_d = cfgByte_q;
        eraseArmed_d = eraseArmed_q; progArmed_d = progArmed_q;
        cfgProg_d = cfgProg_q;    walkIdx_d = walkIdx_q; eeFall_d = eeFall_q;
        eraseTmr_d = eraseTmr_q;  eeTmr_d = eeTmr_q;     pulse_d = pulse_q;
        nvm_d = nvm_q;            nvm_d.strobe = 1'b0;
        bufWe = 1'b0;  fileWe = 1'b0;  fileVal = 8'h00;
        eraseStart = 1'b0;  inc2Exec = 1'b0;  wrNow = 1'b0;
        // Internal timers; EEPROM end clears the write-start bit
        if (eraseTmr_q != 9'h000)
            eraseTmr_d = eraseTmr_q - 9'h001;
        if (eeTmr_q != 9'h000) begin
            eeTmr_d = eeTmr_q - 9'h001;
            if (eeTmr_q == 9'h001)
                nvctrl_d[svps_pkg::CTRL_WR] = 1'b0;
        end
        // EEPROM write starts on the 4th falling clock after start bit
        if (!nvctrl_q[svps_pkg::CTRL_WR])
            eeFall_d = 3'h0;
        else if (pgcFall && eeFall_q != svps_pkg::EE_START_FALL) begin
            eeFall_d = eeFall_q + 3'h1;
            if (eeFall_d == svps_pkg::EE_START_FALL) begin
                if (!nvctrl_q[svps_pkg::CTRL_CODE_SEL] &&
                    !nvctrl_q[svps_pkg::CTRL_CFG_SEL] &&
                    nvctrl_q[svps_pkg::CTRL_WRITE_ENABLE_BIT]) begin
                    eeTmr_d      = svps_pkg::EE_CYCLES;
                    nvm_d.strobe = 1'b1;
                    nvm_d.space  = svps_pkg::SPACE_EEPROM;
                    nvm_d.addr   = {6'h00, eeAddr_q};
                    nvm_d.data   = eeprom_data_latch_q;
                end else begin
                    nvctrl_d[svps_pkg::CTRL_WR] = 1'b0;
                end
            end
        end
        case (state_q)
            svps_pkg::SVPS_IDLE: begin
                if (lowVoltageEntryEnable && sync2_q[2] && mclrRise &&
                    !sync2_q[0] && !sync2_q[1]) begin
                    state_d  = svps_pkg::SVPS_SHIFT;
                    inMode_d = 1'b1;
                    gpioEn_d = 1'b0;
                    bitCnt_d = 5'h00;
                    progArmed_d  = 1'b0;
                    eraseArmed_d = 1'b0;
                end
            end
            svps_pkg::SVPS_SHIFT: begin
                if (pgcRise && progArmed_q &&
                    bitCnt_q == svps_pkg::PULSE_RISE_BIT) begin
                    state_d   = svps_pkg::SVPS_PULSE;
                    pulse_d   = 1'b1;
                    walkIdx_d = 7'h00;
                end else if (pgcFall) begin
                    shift_d  = frame;
                    bitCnt_d = bitCnt_q + 5'h01;
                    if (bitCnt_q == svps_pkg::LAST_BIT) begin
                        bitCnt_d = 5'h00;
                        case (frame[3:0])
                            svps_pkg::CMD_CORE: begin
                                if (op[15:8] == svps_pkg::OP_MOVLW)
                                    wreg_d = op[7:0];
                                else if (op[15:8] == svps_pkg::OP_MOVWF) begin
                                    fileWe  = 1'b1;
                                    fileVal = wreg_q;
                                end else if (op[15:12] == svps_pkg::OP_BSF) begin
                                    fileWe  = 1'b1;
                                    fileVal = fileCur | (8'h01 << op[11:9]);
                                end else if (op[15:12] == svps_pkg::OP_BCF) begin
                                    fileWe  = 1'b1;
                                    fileVal = fileCur & ~(8'h01 << op[11:9]);
                                end
                            end
                            svps_pkg::CMD_TBLWR: begin
                                eraseArmed_d = 1'b0;
                                if (tbl_q == svps_pkg::ERASE_HI_ADDR &&
                                    op == svps_pkg::ERASE_KEY1)
                                    eraseArmed_d = 1'b1;
                                else if (tbl_q == svps_pkg::ERASE_LO_ADDR &&
                                         op == svps_pkg::ERASE_KEY2 &&
                                         eraseArmed_q) begin
                                    eraseStart = 1'b1;
                                    eraseTmr_d = svps_pkg::ERASE_CYCLES;
                                end else
                                    bufWe = 1'b1;
                            end
                            svps_pkg::CMD_TBLWR_INC2: begin
                                bufWe    = 1'b1;
                                inc2Exec = 1'b1;
                                tbl_d    = tbl_q + 22'h000002;
                            end
                            svps_pkg::CMD_TBLWR_PROG: begin
                                progArmed_d = 1'b1;
                                if (tbl_q[21:20] == svps_pkg::CFG_SPACE_TAG) begin
                                    cfgProg_d  = 1'b1;
                                    cfgByte_d  = tbl_q[0] ? op[15:8] : op[7:0];
                                    progBase_d = tbl_q;
                                end else begin
                                    cfgProg_d  = 1'b0;
                                    bufWe      = 1'b1;
                                    progBase_d = {tbl_q[21:svps_pkg::BUF_IDX_W],
                                                  6'h00};
                                end
                            end
                            default: ;
                        endcase
                    end
                end
            end
            svps_pkg::SVPS_PULSE: begin
                // Walk the buffer out while the clock is held high
                if (walkIdx_q < walkLen) begin
                    walkIdx_d    = walkIdx_q + 7'h01;
                    nvm_d.strobe = 1'b1;
                    if (cfgProg_q) begin
                        nvm_d.space = svps_pkg::SPACE_CONFIG;
                        nvm_d.addr  = progBase_q;
                        nvm_d.data  = cfgByte_q;
                    end else begin
                        nvm_d.space = svps_pkg::SPACE_CODE;
                        nvm_d.addr  = progBase_q | {15'h0000, walkIdx_q};
                        nvm_d.data  = walkIdx_q[0] ?
                            wordBuf[walkIdx_q[5:1]][15:8] :
                            wordBuf[walkIdx_q[5:1]][7:0];
                    end
                end
                if (pgcFall) begin
                    state_d     = svps_pkg::SVPS_SHIFT;
                    pulse_d     = 1'b0;
                    progArmed_d = 1'b0;
                    shift_d     = frame;
                    bitCnt_d    = bitCnt_q + 5'h01;
                end
            end
            default: state_d = svps_pkg::SVPS_IDLE;
        endcase
        // Core file writes; the start bit needs write enable
        if (fileWe) begin
            case (op[7:0])
                svps_pkg::FILE_TBL_U:     tbl_d[21:16] = fileVal[5:0];
                svps_pkg::FILE_TBL_H:     tbl_d[15:8]  = fileVal;
                svps_pkg::FILE_TBL_L:     tbl_d[7:0]   = fileVal;
                svps_pkg::FILE_EE_DATA:   eeprom_data_latch_d       = fileVal;
                svps_pkg::FILE_EE_ADDR_L: eeAddr_d[7:0]  = fileVal;
                svps_pkg::FILE_EE_ADDR_H: eeAddr_d[15:8] = fileVal;
                svps_pkg::FILE_NVCTRL: begin
                    wrNow    = nvctrl_d[svps_pkg::CTRL_WR];
                    nvctrl_d = fileVal;
                    nvctrl_d[svps_pkg::CTRL_WR] = wrNow |
                        (fileVal[svps_pkg::CTRL_WR] &
                         nvctrl_q[svps_pkg::CTRL_WRITE_ENABLE_BIT]);
                end
                default: ;
            endcase
        end
        // Master clear low leaves the mode from any state
        if (state_q != svps_pkg::SVPS_IDLE && !sync2_q[3]) begin
            state_d  = svps_pkg::SVPS_IDLE;
            inMode_d = 1'b0;
            gpioEn_d = 1'b1;
            pulse_d  = 1'b0;
        end
    end

    // Sequencer registers
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= svps_pkg::SVPS_IDLE;  inMode_q <= 1'b0;
            gpioEn_q <= 1'b1;       bitCnt_q <= 5'h00;    shift_q <= 20'h00000;
            wreg_q <= 8'h00;        nvctrl_q <= svps_pkg::NVCTRL_RESET;
            tbl_q <= 22'h000000;    progBase_q <= 22'h000000;
            eeAddr_q <= 16'h0000;   eeprom_data_latch_q <= 8'h00;    cfgByte_q <= 8'h00;
            eraseArmed_q <= 1'b0;   progArmed_q <= 1'b0;  cfgProg_q <= 1'b0;
            walkIdx_q <= 7'h00;     eeFall_q <= 3'h0;
            eraseTmr_q <= 9'h000;   eeTmr_q <= 9'h000;    pulse_q <= 1'b0;
            nvm_q <= '0;            eraseBusy <= 1'b0;    eeWriteBusy <= 1'b0;
        end else begin
            state_q <= state_d;     inMode_q <= inMode_d; gpioEn_q <= gpioEn_d;
            bitCnt_q <= bitCnt_d;   shift_q <= shift_d;   wreg_q <= wreg_d;
            nvctrl_q <= nvctrl_d;   tbl_q <= tbl_d;       progBase_q <= progBase_d;
            eeAddr_q <= eeAddr_d;   eeprom_data_latch_q <= eeprom_data_latch_d; cfgByte_q <= cfgByte_d;
            eraseArmed_q <= eraseArmed_d; progArmed_q <= progArmed_d;
            cfgProg_q <= cfgProg_d; walkIdx_q <= walkIdx_d; eeFall_q <= eeFall_d;
            eraseTmr_q <= eraseTmr_d; eeTmr_q <= eeTmr_d; pulse_q <= pulse_d;
            nvm_q <= nvm_d;
            eraseBusy   <= (eraseTmr_d != 9'h000);
            eeWriteBusy <= (eeTmr_d != 9'h000);
        end
    end

    // Write buffer word store: low byte even address, high byte odd
    always_ff @(posedge clk) begin
        if (bufWe)
            wordBuf[tbl_q[5:1]] <= op;
    end

    assign progModeActive      = inMode_q;
    assign unusedIoHighZ       = inMode_q;
    assign sharedPinGpioEnable = gpioEn_q;
    assign programPulse        = pulse_q;
    assign writeControl        = nvctrl_q;
    assign nvmWrite            = nvm_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    AST_ENTRY_LVP: assert property ($rose(progModeActive) |->
        $past(lowVoltageEntryEnable))
        else $error("entry without low-voltage enable");
    AST_ENTRY_ORDER: assert property ($rose(progModeActive) |->
        $past(sync2_q[2]) && !$past(sync2_q[0]) && !$past(sync2_q[1]))
        else $error("entry with wrong pin levels");
    AST_GPIO_OFF: assert property (progModeActive |->
        !sharedPinGpioEnable && unusedIoHighZ)
        else $error("select pin still general purpose in mode");
    AST_ERASE: assert property (eraseStart && sync2_q[3] |=>
        eraseBusy [*8])
        else $error("bulk erase did not start");
    AST_PULSE_HIGH: assert property (programPulse |->
        $past(sync2_q[0]) || $past(programPulse) == 1'b0)
        else $error("pulse continued with clock low");
    AST_PULSE_END: assert property (programPulse && pgcFall |=>
        !programPulse)
        else $error("pulse did not end on clock fall");
    AST_REGION: assert property (nvmWrite.strobe &&
        nvmWrite.space == svps_pkg::SPACE_CODE |->
        nvmWrite.addr[21:6] == progBase_q[21:6])
        else $error("code byte outside region");
    AST_INC2: assert property (inc2Exec && sync2_q[3] |=>
        tbl_q == $past(tbl_q) + 22'h000002)
        else $error("pointer not advanced by two");
    AST_EE_START: assert property ($rose(eeWriteBusy) |->
        nvmWrite.strobe && nvmWrite.space == svps_pkg::SPACE_EEPROM)
        else $error("EEPROM write without byte strobe");
    AST_EE_CLEAR: assert property ($fell(eeWriteBusy) |->
        !writeControl[svps_pkg::CTRL_WR] || $past(fileWe))
        else $error("start bit not cleared at write end");
    AST_CFG_ONE: assert property (nvmWrite.strobe &&
        nvmWrite.space == svps_pkg::SPACE_CONFIG |=> !nvmWrite.strobe)
        else $error("more than one configuration byte");

    COV_ENTRY: cover property ($rose(progModeActive));
    COV_ERASE: cover property ($rose(eraseBusy));
    COV_PULSE: cover property ($rose(programPulse));
    COV_EEWR:  cover property ($rose(eeWriteBusy));
endmodule

// File: inc/svps_pkg.sv
// Purpose: Constants and types for the serial program/verify sequencer
// Assumes: 50 MHz system clock, link pins sampled by that clock
// Notes:   File addresses and internal timer lengths are local choices
package svps_pkg;
    localparam int CLK_PERIOD_NS = 20;
    // Serial frame: 4-bit command then 16-bit payload, both LSB first
    localparam int CMD_BITS   = 4;
    localparam int FRAME_BITS = 20;
    localparam logic [4:0] LAST_BIT       = 5'h13;
    localparam logic [4:0] PULSE_RISE_BIT = 5'h03;  // 4th clock of a frame
    localparam logic [2:0] EE_START_FALL  = 3'h4;   // 4th falling edge
    // Command codes
    localparam logic [3:0] CMD_CORE       = 4'h0;
    localparam logic [3:0] CMD_TBLWR      = 4'hc;
    localparam logic [3:0] CMD_TBLWR_INC2 = 4'hd;
    localparam logic [3:0] CMD_TBLWR_PROG = 4'hf;
    // Bulk erase keys and control addresses
    localparam logic [21:0] ERASE_HI_ADDR = 22'h3c0005;
    localparam logic [21:0] ERASE_LO_ADDR = 22'h3c0004;
    localparam logic [15:0] ERASE_KEY1    = 16'h3f3f;
    localparam logic [15:0] ERASE_KEY2    = 16'h8f8f;
    // Address spaces
    localparam logic [21:0] ID_BASE_ADDR  = 22'h200000;
    localparam logic [1:0]  CFG_SPACE_TAG = 2'h3;   // table_pointer[21:20]
    // Buffers
    localparam int WRITE_BUF_BYTES = 64;
    localparam int ERASE_BUF_BYTES = 64;
    localparam int BUF_IDX_W       = 6;
    localparam logic [6:0] WALK_FULL = 7'h40;
    localparam logic [6:0] WALK_ONE  = 7'h01;
    // Core instruction subset
    localparam logic [7:0] OP_MOVLW = 8'h0e;
    localparam logic [7:0] OP_MOVWF = 8'h6e;
    localparam logic [3:0] OP_BSF   = 4'h8;
    localparam logic [3:0] OP_BCF   = 4'h9;
    // File addresses reachable through core instructions
    localparam logic [7:0] FILE_TBL_U     = 8'hf8;
    localparam logic [7:0] FILE_TBL_H     = 8'hf7;
    localparam logic [7:0] FILE_TBL_L     = 8'hf6;
    localparam logic [7:0] FILE_NVCTRL    = 8'ha6;
    localparam logic [7:0] FILE_EE_DATA   = 8'ha8;
    localparam logic [7:0] FILE_EE_ADDR_L = 8'ha9;
    localparam logic [7:0] FILE_EE_ADDR_H = 8'haa;
    // nonvolatile_write_control fields
    localparam int CTRL_CODE_SEL = 7;
    localparam int CTRL_CFG_SEL  = 6;
    localparam int CTRL_WRITE_ENABLE_BIT     = 2;
    localparam int CTRL_WR       = 1;
    localparam logic [7:0] NVCTRL_RESET = 8'h00;
    // Internal erase and EEPROM write durations
    localparam int ERASE_TIME_NS    = 5000;
    localparam int EE_WRITE_TIME_NS = 4000;
    localparam logic [8:0] ERASE_CYCLES =
        9'((ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [8:0] EE_CYCLES =
        9'((EE_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum logic [2:0] {
        SVPS_IDLE  = 3'h1,
        SVPS_SHIFT = 3'h2,
        SVPS_PULSE = 3'h4
    } svps_state_e;

    typedef enum logic [1:0] {
        SPACE_CODE   = 2'h0,
        SPACE_CONFIG = 2'h1,
        SPACE_EEPROM = 2'h2
    } svps_space_e;

    typedef struct packed {
        logic        strobe;
        svps_space_e space;
        logic [21:0] addr;
        logic [7:0]  data;
    } svps_nvm_write_s;
endpackage

// File: sim/svps_programmer.sv
// Purpose: Programmer model driving the serial link of the sequencer
// Assumes: Link clock high 4 clk and low 8 clk, i.e. a 240 ns link period
// Notes:   Link clock stands low between frames
module svps_programmer (
    input  wire logic clk,  // System clock
    output logic      sck,  // Link clock
    output logic      dat,  // Link data
    output logic      sel,  // Program select
    output logic      mclr  // Master clear
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle pin levels
    initial {sck, dat, sel, mclr} = 4'h0;
    task automatic wt(int n);
        repeat (n) @(posedge clk);
    endtask
    // Clock and data low, select high, then master clear
    task automatic enter();
        sel <= 1'b1;
        wt(8);
        mclr <= 1'b1;
        wt(8);
    endtask
    task automatic leave();
        {sel, mclr} <= 2'b00;
        wt(8);
    endtask
    // One frame; hold is the counted width of the 4th clock high
    task automatic frame(logic [3:0] c, logic [15:0] p, int hold);
        logic [19:0] f;
        f = {p, c};
        for (int i = 0; i < 20; i++) begin
            dat <= f[i];
            wt(4);
            sck <= 1'b1;
            wt(i == 3 ? hold : 4);
            sck <= 1'b0;
            wt(4);
        end
    endtask
endmodule

// File: sim/svps_sequencer_tb.sv
// Purpose: Self-checking bench of the program/verify sequencer
// Assumes: 50 MHz clk, programmer model on the link pins
// Notes:   Array bytes are counted on the write strobe
`define CHK(g, e) begin testsRun++; if ((g) !== (e)) begin miscompares++; \
    $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module svps_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, reset, lvEn, sck, dat, sel, mclr, mode, hz, gpio, pulse;
    logic eraseBusy, eeBusy;
    logic [7:0] ctrl, firstByte, idByte;
    svps_pkg::svps_nvm_write_s nvm, lastNvm;
    int miscompares = 0;
    int testsRun = 0;
    int strobes = 0;
    svps_sequencer u_dut (.clk(clk), .reset(reset),
        .lowVoltageEntryEnable(lvEn), .progSerialClockPin(sck),
        .progSerialDataPin(dat), .lowVoltageProgSelectPin(sel),
        .masterClearPin(mclr), .progModeActive(mode), .unusedIoHighZ(hz),
        .sharedPinGpioEnable(gpio), .programPulse(pulse),
        .eraseBusy(eraseBusy), .eeWriteBusy(eeBusy),
        .writeControl(ctrl), .nvmWrite(nvm));
    svps_programmer u_p (.clk(clk), .sck(sck), .dat(dat), .sel(sel),
        .mclr(mclr));
    // Clock generation
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Count written bytes; keep the last one and two watched bytes
    always @(posedge clk) if (nvm.strobe === 1'b1) begin
        strobes++;
        lastNvm = nvm;
        if (nvm.addr === 22'h0) firstByte = nvm.data;
        if (nvm.addr === 22'h200000) idByte = nvm.data;
    end
    task automatic wt(int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic ptr(logic [21:0] a);
        u_p.frame(4'h0, {8'h0e, 2'b00, a[21:16]}, 4);
        u_p.frame(4'h0, 16'h6ef8, 4);
        u_p.frame(4'h0, {8'h0e, a[15:8]}, 4);
        u_p.frame(4'h0, 16'h6ef7, 4);
        u_p.frame(4'h0, {8'h0e, a[7:0]}, 4);
        u_p.frame(4'h0, 16'h6ef6, 4);
    endtask
    task automatic t_entry();
        u_p.enter();
        `CHK(mode, 1'b0)
        u_p.leave();
        lvEn <= 1'b1;
        u_p.enter();
        `CHK(mode, 1'b1)
        `CHK(hz, 1'b1)
        `CHK(gpio, 1'b0)
        $display("entry test done");
    endtask
    task automatic t_erase();
        ptr(22'h3c0005);
        u_p.frame(4'hc, 16'h3f3f, 4);
        ptr(22'h3c0004);
        u_p.frame(4'hc, 16'h8f8f, 4);
        wt(4);
        `CHK(eraseBusy, 1'b1)
        u_p.frame(4'h0, 16'h0000, 4);
        wt(20);
        `CHK(eraseBusy, 1'b0)
        u_p.frame(4'h0, 16'h0000, 4);
        u_p.frame(4'h0, 16'h0000, 4);
        $display("erase test done");
    endtask
    task automatic t_code();
        ptr(22'h000000);
        u_p.frame(4'hd, 16'h1234, 4);
        u_p.frame(4'hf, 16'h5678, 4);
        fork
            u_p.frame(4'h0, 16'h0000, 100);
            begin wt(60); `CHK(pulse, 1'b1) end
        join
        `CHK(pulse, 1'b0)
        `CHK(strobes, 64)
        `CHK(firstByte, 8'h34)
        $display("code write test done");
    endtask
    task automatic t_id();
        int n;
        n = strobes;
        u_p.frame(4'h0, 16'h8ea6, 4);
        u_p.frame(4'h0, 16'h9ca6, 4);
        ptr(22'h200000);
        u_p.frame(4'hd, 16'h1122, 4);
        u_p.frame(4'hd, 16'h3344, 4);
        u_p.frame(4'hd, 16'h5566, 4);
        u_p.frame(4'hf, 16'h7788, 4);
        u_p.frame(4'h0, 16'h0000, 100);
        `CHK(strobes - n, 64)
        `CHK(idByte, 8'h22)
        `CHK(ctrl[7], 1'b1)
        $display("id write test done");
    endtask
    task automatic cfg(logic [21:0] a, logic [7:0] e);
        int n;
        n = strobes;
        ptr(a);
        u_p.frame(4'hf, 16'hab5c, 4);
        u_p.frame(4'h0, 16'h0000, 100);
        `CHK(strobes - n, 1)
        `CHK(lastNvm.space, svps_pkg::SPACE_CONFIG)
        `CHK(lastNvm.addr, a)
        `CHK(lastNvm.data, e)
    endtask
    task automatic t_config();
        cfg(22'h300000, 8'h5c);
        cfg(22'h300001, 8'hab);
        $display("config write test done");
    endtask
    task automatic t_eeprom();
        u_p.frame(4'h0, 16'h9ea6, 4);
        u_p.frame(4'h0, 16'h9ca6, 4);
        u_p.frame(4'h0, 16'h0e5a, 4);
        u_p.frame(4'h0, 16'h6ea8, 4);
        u_p.frame(4'h0, 16'h84a6, 4);
        u_p.frame(4'h0, 16'h82a6, 4);
        fork
            u_p.frame(4'h0, 16'h0000, 4);
            begin wt(100); `CHK(eeBusy, 1'b1) end
        join
        `CHK(lastNvm.space, svps_pkg::SPACE_EEPROM)
        `CHK(lastNvm.data, 8'h5a)
        wt(60);
        `CHK(ctrl, 8'h04)
        $display("eeprom test done");
    endtask
    task automatic finish_test();
        $display("checks %0d miscompares %0d", testsRun, miscompares);
        if (miscompares == 0 && testsRun > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Main sequence
    initial begin
        {reset, lvEn} = 2'b10;
        wt(2);
        reset <= 1'b0;
        wt(2);
        `CHK(gpio, 1'b1)
        `CHK(ctrl, 8'h00)
        t_entry();
        t_erase();
        t_code();
        t_id();
        t_config();
        t_eeprom();
        finish_test();
    end
    // Watchdog
    initial begin
        wt(40000);
        miscompares++;
        finish_test();
    end
endmodule
